// File: hdl/sbt_params.svh
`ifndef SBT_PARAMS_SVH
`define SBT_PARAMS_SVH
// Register byte offsets.
`define SBT_OFF_CMD      8'h00
`define SBT_OFF_CFG      8'h04
`define SBT_OFF_RANGE    8'h08
`define SBT_OFF_BPA      8'h0c
`define SBT_OFF_STATUS   8'h10
`define SBT_OFF_LASTLOC  8'h14
`define SBT_OFF_BPLIST   8'h18
`define SBT_OFF_REGS     8'h1c
// Command register fields.
`define SBT_CMD_GO       0
`define SBT_CMD_RESET    1
`define SBT_CMD_ARM      2
`define SBT_CMD_DISARM   3
`define SBT_CMD_DISALL   4
`define SBT_CMD_SELECT   5
`define SBT_CMD_PATCH    6
`define SBT_CMD_PRELOAD  7
`define SBT_CMD_INSPECT  8
`define SBT_CMD_CLRERR   9
// Config register fields.
`define SBT_CFG_MODE_LSB  0
`define SBT_CFG_TRACE_LSB 2
`define SBT_CFG_STEP      4
`define SBT_CFG_MODEV     5
`define SBT_CFG_QUAL_LSB  6
`define SBT_CFG_REG_LSB   8
`define SBT_CFG_CNT_LSB   12
`define SBT_CFG_KEY_LSB   16
// Bounds and reset values.
`define SBT_RANGE_RST    32'hffff_0000
`define SBT_PATCH_MAX    6'h1d
`define SBT_LINE_MASK    16'h000f
`define SBT_RESP_OKAY    2'b00
`define SBT_RESP_SLVERR  2'b10
`endif

// File: hdl/sbt_pkg.sv
package sbt_pkg;
   typedef enum logic [1:0] {SBT_EMU_SYSTEM, SBT_EMU_PARTIAL, SBT_EMU_FULL, SBT_EMU_BAD} sbt_emu_t;
   typedef enum logic [1:0] {SBT_TR_OFF, SBT_TR_ALL, SBT_TR_BRANCH, SBT_TR_BAD} sbt_trace_t;
   typedef enum logic [1:0] {SBT_Q_ANY, SBT_Q_WRITE, SBT_Q_READ, SBT_Q_ANY2} sbt_qual_t;
   typedef enum logic [1:0] {SBT_K_SPACE, SBT_K_HEX, SBT_K_RETURN, SBT_K_NONE} sbt_key_t;
endpackage

// File: hdl/sbt_top.sv
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "sbt_params.svh"

module sbt_top #(
   parameter int NUM_BP = 2,
   parameter int NUM_REGS = 8
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [15:0] TGT_ADDR,
   input wire logic TGT_VALID,
   input wire logic TGT_WRITE,
   input wire logic TGT_FETCH,
   input wire logic TGT_BRANCH,
   input wire logic [7:0] TGT_PSW,
   output logic TGT_RUN,
   output logic TGT_RESET,
   output sbt_pkg::sbt_emu_t EMU_MODE,
   output logic [15:0] MEM_ADDR,
   output logic [7:0] MEM_WDATA,
   output logic MEM_WE,
   output logic [2:0] REG_SEL,
   output logic [7:0] REG_WDATA,
   output logic REG_WE,
   output logic TRACE_VALID,
   output logic [15:0] TRACE_LOC,
   output logic [7:0] TRACE_PSW,
   output logic TRACE_BRANCH,
   output logic BP_EVENT,
   output logic NEW_LINE
);
   import sbt_pkg::*;

   // Slot search and read mux are written for exactly these sizes.
   if (NUM_BP != 2 || NUM_REGS != 8) begin : g_size_check
      $error("sbt_top: only two breakpoints, eight registers");
   end

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   logic aw_q, w_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic wr_fire;
   logic [31:0] rdata_d;
   logic rerr_d, werr_d;
   assign S_AXI_AWREADY = !aw_q && !S_AXI_BVALID;
   assign S_AXI_WREADY = !w_q && !S_AXI_BVALID;
   assign S_AXI_ARREADY = !S_AXI_RVALID;
   assign wr_fire = aw_q && w_q && !S_AXI_BVALID;

   // Address and data are captured independently so either may come first.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_q <= 1'b1;
            awaddr_q <= S_AXI_AWADDR;
         end else if (wr_fire) aw_q <= 1'b0;
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_q <= 1'b1;
            wdata_q <= S_AXI_WDATA;
         end else if (wr_fire) w_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `SBT_RESP_OKAY;
      end else if (wr_fire) begin
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP <= werr_d ? `SBT_RESP_SLVERR : `SBT_RESP_OKAY;
      end else if (S_AXI_BREADY) S_AXI_BVALID <= 1'b0;
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0000_0000;
         S_AXI_RRESP <= `SBT_RESP_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA <= rdata_d;
         S_AXI_RRESP <= rerr_d ? `SBT_RESP_SLVERR : `SBT_RESP_OKAY;
      end else if (S_AXI_RREADY) S_AXI_RVALID <= 1'b0;
   end

   // ----------------------------------------
   // Control state
   // ----------------------------------------
   logic [15:0] cfg_q;
   logic [15:0] lo_q, hi_q;
   logic [15:0] bpa_q;
   logic [NUM_BP-1:0] bp_on_q;
   logic [15:0] bp_addr_q [NUM_BP];
   sbt_qual_t bp_qual_q [NUM_BP];
   logic [NUM_BP-1:0] bp_hit;
   sbt_trace_t trace_q;
   logic step_q, run_q, toomany_q, notactive_q, bphit_q, insp_on_q;
   logic [15:0] last_q;
   logic [7:0] regs_q [NUM_REGS];
   logic [15:0] insp_q;
   logic [4:0] left_q;
   logic [1:0] pidx_q;
   logic [31:0] pbuf_q;
   logic is_cmd;
   logic [9:0] cmd;
   sbt_trace_t new_tr;
   logic in_win, want_rec, any_hit;
   assign is_cmd = wr_fire && awaddr_q == `SBT_OFF_CMD;
   assign cmd = is_cmd ? wdata_q[9:0] : 10'h000;
   assign new_tr = sbt_trace_t'(wdata_q[`SBT_CFG_TRACE_LSB +: 2]);
   // Mode 2 refuses branch trace; illegal codes refused too.
   always_comb begin
      werr_d = 1'b0;
      if (wr_fire && awaddr_q == `SBT_OFF_CFG && (new_tr == SBT_TR_BAD ||
          (new_tr == SBT_TR_BRANCH && EMU_MODE == SBT_EMU_FULL))) werr_d = 1'b1;
      if (wr_fire && awaddr_q == `SBT_OFF_RANGE && wdata_q[31:16] < wdata_q[15:0])
         werr_d = 1'b1;
      if (is_cmd && wdata_q[`SBT_CMD_SELECT] && wdata_q[`SBT_CFG_MODEV + 16] &&
          wdata_q[17:16] == 2'b11) werr_d = 1'b1;
   end

   // Configuration, window and patch staging.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         cfg_q <= 16'h0000;
         trace_q <= SBT_TR_OFF;
         step_q <= 1'b0;
         lo_q <= 16'(`SBT_RANGE_RST);
         hi_q <= 16'(`SBT_RANGE_RST >> 16);
         bpa_q <= 16'h0000;
         pbuf_q <= 32'h0000_0000;
      end else if (wr_fire && !werr_d) begin
         case (awaddr_q)
            `SBT_OFF_CFG: begin
               cfg_q <= wdata_q[15:0];
               trace_q <= new_tr;
               step_q <= wdata_q[`SBT_CFG_STEP];
            end
            `SBT_OFF_RANGE: begin
               lo_q <= wdata_q[15:0];
               hi_q <= wdata_q[31:16];
            end
            `SBT_OFF_BPA: bpa_q <= wdata_q[15:0];
            `SBT_OFF_REGS: pbuf_q <= wdata_q;
            default: ;
         endcase
      end
   end

   // Target selection: mode is 0 unless MODEV is set; a select with MODEV set and mode 3 is refused and keeps the old mode.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) EMU_MODE <= SBT_EMU_SYSTEM;
      else if (cmd[`SBT_CMD_SELECT] && !werr_d) begin
         if (wdata_q[`SBT_CFG_MODEV + 16]) EMU_MODE <= sbt_emu_t'(wdata_q[17:16]);
         else EMU_MODE <= SBT_EMU_SYSTEM;
      end
   end

   // ----------------------------------------
   // Breakpoints
   // ----------------------------------------
   generate
      for (genvar i = 0; i < NUM_BP; i++) begin : g_bp
         logic qual_ok;
         always_comb begin
            case (bp_qual_q[i])
               SBT_Q_WRITE: qual_ok = TGT_WRITE;
               SBT_Q_READ: qual_ok = !TGT_WRITE;
               default: qual_ok = 1'b1;
            endcase
         end
         assign bp_hit[i] = bp_on_q[i] && TGT_VALID && run_q && qual_ok &&
                            TGT_ADDR == bp_addr_q[i];
      end
   endgenerate
   assign any_hit = |bp_hit;

   // Arm into the first free slot; a clear by address that misses is flagged.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         bp_on_q <= '0;
         toomany_q <= 1'b0;
         notactive_q <= 1'b0;
         for (int j = 0; j < NUM_BP; j++) begin
            bp_addr_q[j] <= 16'h0000;
            bp_qual_q[j] <= SBT_Q_ANY;
         end
      end else begin
         if (cmd[`SBT_CMD_CLRERR]) begin
            toomany_q <= 1'b0;
            notactive_q <= 1'b0;
         end
         if (cmd[`SBT_CMD_DISALL]) bp_on_q <= '0;
         else if (cmd[`SBT_CMD_DISARM]) begin
            for (int j = 0; j < NUM_BP; j++)
               if (bp_on_q[j] && bp_addr_q[j] == bpa_q) bp_on_q[j] <= 1'b0;
            if (!(bp_on_q[0] && bp_addr_q[0] == bpa_q) &&
                !(bp_on_q[1] && bp_addr_q[1] == bpa_q)) notactive_q <= 1'b1;
         end else if (cmd[`SBT_CMD_ARM]) begin
            if (&bp_on_q) toomany_q <= 1'b1;
            else begin
               bp_on_q[bp_on_q[0]] <= 1'b1;
               bp_addr_q[bp_on_q[0]] <= bpa_q;
               bp_qual_q[bp_on_q[0]] <= sbt_qual_t'(cfg_q[`SBT_CFG_QUAL_LSB +: 2]);
            end
         end
      end
   end

   // ----------------------------------------
   // Run control, trace and reset
   // ----------------------------------------
   assign in_win = TGT_ADDR >= lo_q && TGT_ADDR <= hi_q;
   always_comb begin
      case (trace_q)
         SBT_TR_ALL: want_rec = 1'b1;
         SBT_TR_BRANCH: want_rec = TGT_BRANCH && EMU_MODE != SBT_EMU_FULL;
         default: want_rec = 1'b0;
      endcase
   end

   // A hit always traces the last instruction, regardless of mode.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         run_q <= 1'b0;
         bphit_q <= 1'b0;
         TRACE_VALID <= 1'b0;
         TRACE_LOC <= 16'h0000;
         TRACE_PSW <= 8'h00;
         TRACE_BRANCH <= 1'b0;
         BP_EVENT <= 1'b0;
         last_q <= 16'h0000;
      end else begin
         TRACE_VALID <= 1'b0;
         BP_EVENT <= 1'b0;
         if (TGT_VALID && TGT_FETCH && run_q) last_q <= TGT_ADDR;
         if (any_hit) begin
            run_q <= 1'b0;
            bphit_q <= 1'b1;
            BP_EVENT <= 1'b1;
            TRACE_VALID <= 1'b1;
            TRACE_LOC <= last_q;
            TRACE_PSW <= TGT_PSW;
            TRACE_BRANCH <= 1'b0;
         end else if (TGT_VALID && TGT_FETCH && run_q && want_rec && in_win) begin
            TRACE_VALID <= 1'b1;
            TRACE_LOC <= TGT_ADDR;
            TRACE_PSW <= TGT_PSW;
            TRACE_BRANCH <= TGT_BRANCH && EMU_MODE != SBT_EMU_FULL;
            if (step_q) run_q <= 1'b0;
         end else if (cmd[`SBT_CMD_GO]) begin
            run_q <= 1'b1;
            bphit_q <= 1'b0;
         end
      end
   end
   assign TGT_RUN = run_q;

   // Single-cycle reset pulse into the target.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) TGT_RESET <= 1'b0;
      else TGT_RESET <= cmd[`SBT_CMD_RESET];
   end

   // ----------------------------------------
   // Memory patch, inspect and register preload
   // ----------------------------------------
   sbt_key_t key;
   assign key = sbt_key_t'(wdata_q[`SBT_CFG_KEY_LSB +: 2]);
   // Patch streams bytes from the staging word, one per cycle; only four bytes
   // are staged, so longer strings are issued as several patch commands.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         insp_q <= 16'h0000;
         insp_on_q <= 1'b0;
         left_q <= 5'h00;
         pidx_q <= 2'h0;
         MEM_ADDR <= 16'h0000;
         MEM_WDATA <= 8'h00;
         MEM_WE <= 1'b0;
         NEW_LINE <= 1'b0;
      end else begin
         MEM_WE <= 1'b0;
         NEW_LINE <= 1'b0;
         if (left_q != 5'h00) begin
            MEM_WE <= 1'b1;
            MEM_ADDR <= insp_q;
            MEM_WDATA <= pbuf_q[8*(3-pidx_q) +: 8];
            insp_q <= insp_q + 16'h0001;
            pidx_q <= pidx_q + 2'h1;
            left_q <= left_q - 5'h01;
         end else if (cmd[`SBT_CMD_PATCH] && wdata_q[20:16] != 5'h00 && wdata_q[20:16] <= 5'h04) begin
            insp_q <= bpa_q;
            pidx_q <= 2'h0;
            left_q <= wdata_q[20:16];
         end else if (cmd[`SBT_CMD_INSPECT]) begin
            // Keys outside an open session are ignored, so a late key cannot touch memory.
            case (key)
               SBT_K_HEX: if (insp_on_q) begin
                  MEM_WE <= 1'b1;
                  MEM_ADDR <= insp_q;
                  MEM_WDATA <= wdata_q[31:24];
                  insp_q <= insp_q + 16'h0001;
                  NEW_LINE <= ((insp_q + 16'h0001) & `SBT_LINE_MASK) == 16'h0000;
               end
               SBT_K_SPACE: if (insp_on_q) begin
                  insp_q <= insp_q + 16'h0001;
                  NEW_LINE <= ((insp_q + 16'h0001) & `SBT_LINE_MASK) == 16'h0000;
               end
               SBT_K_RETURN: insp_on_q <= 1'b0;
               default: begin
                  insp_q <= bpa_q;
                  insp_on_q <= 1'b1;
               end
            endcase
         end
      end
   end

   // Preload one register per value; later registers keep their contents.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         REG_WE <= 1'b0;
         REG_SEL <= 3'h0;
         REG_WDATA <= 8'h00;
         for (int j = 0; j < NUM_REGS; j++) regs_q[j] <= 8'h00;
      end else begin
         REG_WE <= 1'b0;
         if (cmd[`SBT_CMD_PRELOAD]) begin
            REG_WE <= 1'b1;
            REG_SEL <= cfg_q[`SBT_CFG_REG_LSB +: 3];
            REG_WDATA <= pbuf_q[7:0];
            regs_q[cfg_q[`SBT_CFG_REG_LSB +: 3]] <= pbuf_q[7:0];
         end
      end
   end

   // Read mux reports mode, flags, breakpoints and the first four registers.
   always_comb begin
      rdata_d = 32'h0000_0000;
      rerr_d = 1'b0;
      case (S_AXI_ARADDR)
         `SBT_OFF_CMD: rdata_d = 32'h0000_0000;
         `SBT_OFF_CFG: rdata_d = {16'h0000, cfg_q};
         `SBT_OFF_RANGE: rdata_d = {hi_q, lo_q};
         `SBT_OFF_BPA: rdata_d = {16'h0000, bpa_q};
         `SBT_OFF_STATUS: rdata_d = {16'h0000, insp_q[11:0], 1'b0, notactive_q, toomany_q, bphit_q};
         `SBT_OFF_LASTLOC: rdata_d = {EMU_MODE, bp_on_q, 12'h000, last_q};
         `SBT_OFF_BPLIST: rdata_d = {bp_addr_q[1], bp_addr_q[0]};
         `SBT_OFF_REGS: rdata_d = {regs_q[3], regs_q[2], regs_q[1], regs_q[0]};
         default: rerr_d = 1'b1;
      endcase
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   bp_stop_a: assert property (@(posedge CLK) disable iff (RST) any_hit |=> !TGT_RUN && BP_EVENT && TRACE_VALID) else $error("hit did not stop target");
   bp_write_a: assert property (@(posedge CLK) disable iff (RST) (bp_hit[0] && bp_qual_q[0] == SBT_Q_WRITE) |-> TGT_WRITE) else $error("write-only fired on read");
   bp_read_a: assert property (@(posedge CLK) disable iff (RST) (bp_hit[0] && bp_qual_q[0] == SBT_Q_READ) |-> !TGT_WRITE) else $error("read-only fired on write");
   bp_full_a: assert property (@(posedge CLK) disable iff (RST) (cmd[`SBT_CMD_ARM] && !cmd[`SBT_CMD_DISARM] && !cmd[`SBT_CMD_DISALL] && &bp_on_q) |=> toomany_q && $stable(bp_on_q)) else $error("third breakpoint taken");
   rst_pulse_a: assert property (@(posedge CLK) disable iff (RST) TGT_RESET |=> !TGT_RESET) else $error("reset pulse too long");
   step_halt_a: assert property (@(posedge CLK) disable iff (RST) (TRACE_VALID && step_q) |-> !TGT_RUN) else $error("step did not halt");
   win_trace_a: assert property (@(posedge CLK) disable iff (RST) (TRACE_VALID && !BP_EVENT) |-> TRACE_LOC >= lo_q && TRACE_LOC <= hi_q) else $error("trace outside window");
   full_branch_a: assert property (@(posedge CLK) disable iff (RST) EMU_MODE == SBT_EMU_FULL |-> trace_q != SBT_TR_BRANCH || !TRACE_BRANCH) else $error("branch trace in full mode");
   off_trace_a: assert property (@(posedge CLK) disable iff (RST) (trace_q == SBT_TR_OFF && !any_hit) |=> !TRACE_VALID || BP_EVENT) else $error("trace while off");
   cv_hit_c: cover property (@(posedge CLK) disable iff (RST) BP_EVENT);
   cv_step_c: cover property (@(posedge CLK) disable iff (RST) TRACE_VALID && step_q);
   cv_line_c: cover property (@(posedge CLK) disable iff (RST) NEW_LINE && MEM_WE);
endmodule // sbt_top
`default_nettype wire

// File: testbench/sbt_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
// -------------------------
// Target processor stand-in
// -------------------------
module sbt_cpu_model (
   input wire logic CLK,
   input wire logic TGT_RUN,
   output logic [15:0] TGT_ADDR,
   output logic TGT_VALID,
   output logic TGT_WRITE,
   output logic TGT_FETCH,
   output logic TGT_BRANCH,
   output logic [7:0] TGT_PSW,
   input wire logic [15:0] MEM_ADDR,
   input wire logic [7:0] MEM_WDATA,
   input wire logic MEM_WE,
   input wire logic [2:0] REG_SEL,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WE
);
   logic [7:0] mem [0:65535];
   logic [7:0] regs [0:7];
   // Memory starts as a known filler so that stray writes show up.
   initial begin
      for (int i = 0; i < 65536; i++) mem[i] = 8'h55;
      for (int i = 0; i < 8; i++) regs[i] = 8'(8'h11 * i);
      TGT_ADDR = 16'hffff;
      TGT_VALID = 1'b0;
      TGT_WRITE = 1'b0;
      TGT_FETCH = 1'b0;
      TGT_BRANCH = 1'b0;
      TGT_PSW = 8'h00;
   end
   // One bus cycle; a halted processor issues nothing at all.
   task automatic access(input logic [15:0] a, input logic w, input logic f, input logic b);
      @(posedge CLK);
      if (TGT_RUN === 1'b1) begin
         TGT_ADDR <= a;
         TGT_VALID <= 1'b1;
         TGT_WRITE <= w;
         TGT_FETCH <= f;
         TGT_BRANCH <= b;
         TGT_PSW <= a[7:0] ^ 8'h5a;
      end
      @(posedge CLK);
      // The released bus shows inverted address and write, and PSW as the inverted address low byte; valid, fetch and branch drop low.
      TGT_ADDR <= ~a;
      TGT_VALID <= 1'b0;
      TGT_WRITE <= ~w;
      TGT_FETCH <= 1'b0;
      TGT_BRANCH <= 1'b0;
      TGT_PSW <= ~a[7:0];
   endtask
   // Patch, inspect and preload writes land in the model's store.
   always @(posedge CLK) begin
      if (MEM_WE === 1'b1) mem[MEM_ADDR] <= MEM_WDATA;
      if (REG_WE === 1'b1) regs[REG_SEL] <= REG_WDATA;
   end
endmodule // sbt_cpu_model
`default_nettype wire

// File: testbench/tb_sbt_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "sbt_params.svh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
   $display("Error %s exp %h got %h", n, e, g); end end
module tb_sbt_top;
   import sbt_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awa, ara, tp, mwd, rwd, tps;
   logic [31:0] wd, rdat;
   logic [1:0] bresp, rresp;
   logic awv, awr, wv, wrdy, bv, brdy, arv, arr, rv, rrdy;
   logic [15:0] ta, ma, tl;
   logic tv, tw, tf, tbr, trun, trst, mwe, rwe, trv, trb, bpe, nl;
   logic [2:0] rs;
   sbt_emu_t emu;
   int fails = 0;
   int n_checks = 0;
   int n_rst = 0;
   int n_mwe = 0;
   int n_nl = 0;
   sbt_top i_dut (.CLK(clk), .RST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
      .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
      .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy),
      .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy), .TGT_ADDR(ta),
      .TGT_VALID(tv), .TGT_WRITE(tw), .TGT_FETCH(tf), .TGT_BRANCH(tbr), .TGT_PSW(tp),
      .TGT_RUN(trun), .TGT_RESET(trst), .EMU_MODE(emu), .MEM_ADDR(ma), .MEM_WDATA(mwd),
      .MEM_WE(mwe), .REG_SEL(rs), .REG_WDATA(rwd), .REG_WE(rwe), .TRACE_VALID(trv),
      .TRACE_LOC(tl), .TRACE_PSW(tps), .TRACE_BRANCH(trb), .BP_EVENT(bpe), .NEW_LINE(nl));
   sbt_cpu_model i_cpu (.CLK(clk), .TGT_RUN(trun), .TGT_ADDR(ta), .TGT_VALID(tv),
      .TGT_WRITE(tw), .TGT_FETCH(tf), .TGT_BRANCH(tbr), .TGT_PSW(tp), .MEM_ADDR(ma),
      .MEM_WDATA(mwd), .MEM_WE(mwe), .REG_SEL(rs), .REG_WDATA(rwd), .REG_WE(rwe));
   // 50 MHz clock.
   initial forever #10 clk = ~clk;
   // Pulse counters; one count per cycle high, so a multi-byte patch counts once per byte.
   always @(posedge clk) begin
      if (trst === 1'b1) n_rst++;
      if (mwe === 1'b1) n_mwe++;
      if (nl === 1'b1) n_nl++;
   end
   // ---------
   // Bus tasks
   // ---------
   task automatic tally_and_finish();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic give_up();
      fails++;
      $display("Error wait bound exp 1 got 0");
      tally_and_finish();
   endtask
   // Address and data are offered together and each dropped when taken.
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int k;
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= 1'b1;
      for (k = 0; k < 40; k++) begin
         @(posedge clk);
         if (awr === 1'b1) awv <= 1'b0;
         if (wrdy === 1'b1) wv <= 1'b0;
         if (bv === 1'b1) begin
            r = bresp;
            brdy <= 1'b0;
            break;
         end
      end
      if (k == 40) give_up();
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rrdy <= 1'b1;
      for (k = 0; k < 40; k++) begin
         @(posedge clk);
         if (arr === 1'b1) arv <= 1'b0;
         if (rv === 1'b1) begin
            d = rdat;
            r = rresp;
            rrdy <= 1'b0;
            break;
         end
      end
      if (k == 40) give_up();
   endtask
   task automatic cmd(input logic [31:0] d);
      logic [1:0] r;
      axw(`SBT_OFF_CMD, d, r);
   endtask
   task automatic wchk(input string n, input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] e);
      logic [1:0] r;
      axw(a, d, r);
      `CHK(n, e, r)
   endtask
   task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axr(a, d, r);
      `CHK(n, e, d & m)
   endtask
   // A fetch, then the record that must or must not follow it.
   task automatic tr(input logic [15:0] a, input logic b, input logic e);
      i_cpu.access(a, 1'b0, 1'b1, b);
      #1;
      `CHK("trace", e, trv)
      if (e) begin
         `CHK("loc", a, tl)
         `CHK("psw", a[7:0] ^ 8'h5a, tps)
         `CHK("branch", b, trb)
      end
   endtask
   // ---------
   // Scenarios
   // ---------
   task automatic s_idle();
      logic [31:0] d;
      logic [1:0] r;
      `CHK("mode", SBT_EMU_SYSTEM, emu)
      rchk("range", `SBT_OFF_RANGE, 32'hffff_ffff, `SBT_RANGE_RST);
      axr(8'h40, d, r);
      `CHK("unmapped", `SBT_RESP_SLVERR, r)
   endtask
   task automatic s_mode();
      for (int m = 0; m < 3; m++) begin
         cmd(32'h0020_0020 | (m << 16));
         `CHK("mode", 2'(m), emu)
      end
      cmd(32'h0002_0020);
      `CHK("mode", SBT_EMU_SYSTEM, emu)
   endtask
   task automatic s_cfg();
      cmd(32'h0022_0020);
      wchk("jmp m2", `SBT_OFF_CFG, 32'h8, `SBT_RESP_SLVERR);
      cmd(32'h0020);
      wchk("tr code", `SBT_OFF_CFG, 32'hc, `SBT_RESP_SLVERR);
      wchk("jmp m0", `SBT_OFF_CFG, 32'h8, `SBT_RESP_OKAY);
      wchk("hi lo", `SBT_OFF_RANGE, 32'h0010_0020, `SBT_RESP_SLVERR);
      wchk("hi eq", `SBT_OFF_RANGE, 32'h0020_0020, `SBT_RESP_OKAY);
   endtask
   task automatic s_bp();
      logic [1:0] r;
      logic h;
      cmd(32'h10);
      axw(`SBT_OFF_BPA, 32'h3007, r);
      for (int q = 0; q < 3; q++) begin
         axw(`SBT_OFF_CFG, q << 6, r);
         cmd(32'h4);
         for (int w = 0; w < 2; w++) begin
            h = (q == 0) || (q == 1 && w == 1) || (q == 2 && w == 0);
            cmd(32'h1);
            i_cpu.access(16'h3007, w[0], 1'b0, 1'b0);
            #1;
            `CHK("hit", h, bpe)
            `CHK("run", !h, trun)
            `CHK("hit rec", h, trv)
         end
         cmd(32'h10);
      end
   endtask
   task automatic s_many();
      logic [1:0] r;
      axw(`SBT_OFF_CFG, 32'h0, r);
      cmd(32'h210);
      for (int i = 0; i < 3; i++) begin
         axw(`SBT_OFF_BPA, 32'h3100 + i, r);
         cmd(32'h4);
      end
      rchk("too many", `SBT_OFF_STATUS, 32'h2, 32'h2);
      rchk("bp on", `SBT_OFF_LASTLOC, 32'h3000_0000, 32'h3000_0000);
      axw(`SBT_OFF_BPA, 32'h3100, r);
      cmd(32'h208);
      rchk("active", `SBT_OFF_STATUS, 32'h4, 32'h0);
      cmd(32'h8);
      rchk("inactive", `SBT_OFF_STATUS, 32'h4, 32'h4);
      cmd(32'h1);
      i_cpu.access(16'h3101, 1'b1, 1'b0, 1'b0);
      #1;
      `CHK("kept", 1'b1, bpe)
      cmd(32'h10);
      cmd(32'h1);
      i_cpu.access(16'h3101, 1'b1, 1'b0, 1'b0);
      #1;
      `CHK("gone", 1'b0, bpe)
   endtask
   task automatic s_reset();
      int b;
      b = n_rst;
      cmd(32'h2);
      repeat (4) @(posedge clk);
      `CHK("pulses", 1, n_rst - b)
   endtask
   task automatic s_preload();
      logic [1:0] r;
      axw(`SBT_OFF_CFG, 32'h300, r);
      axw(`SBT_OFF_REGS, 32'hfa, r);
      cmd(32'h80);
      repeat (3) @(posedge clk);
      `CHK("reg3", 8'hfa, i_cpu.regs[3])
      `CHK("reg4", 8'h44, i_cpu.regs[4])
      rchk("regs", `SBT_OFF_REGS, 32'hff00_0000, 32'hfa00_0000);
   endtask
   task automatic s_patch();
      logic [1:0] r;
      int b;
      b = n_mwe;
      axw(`SBT_OFF_BPA, 32'h3000, r);
      axw(`SBT_OFF_REGS, 32'h3f00_1e00, r);
      cmd(32'h0003_0040);
      for (int k = 0; k < 40 && n_mwe - b < 3; k++) @(posedge clk);
      repeat (3) @(posedge clk);
      `CHK("writes", 3, n_mwe - b)
      `CHK("m3000", 8'h3f, i_cpu.mem[16'h3000])
      `CHK("m3001", 8'h00, i_cpu.mem[16'h3001])
      `CHK("m3002", 8'h1e, i_cpu.mem[16'h3002])
      `CHK("m3003", 8'h55, i_cpu.mem[16'h3003])
   endtask
   task automatic s_inspect();
      logic [1:0] r;
      int bm, bn;
      bm = n_mwe;
      bn = n_nl;
      axw(`SBT_OFF_BPA, 32'h300e, r);
      cmd(32'h0003_0100);
      cmd(32'h0101_0100);
      cmd(32'h0000_0100);
      cmd(32'h0201_0100);
      cmd(32'h0002_0100);
      cmd(32'h0901_0100);
      repeat (3) @(posedge clk);
      `CHK("m300e", 8'h01, i_cpu.mem[16'h300e])
      `CHK("m300f", 8'h55, i_cpu.mem[16'h300f])
      `CHK("m3010", 8'h02, i_cpu.mem[16'h3010])
      `CHK("writes", 2, n_mwe - bm)
      `CHK("lines", 1, n_nl - bn)
   endtask
   task automatic s_trace();
      logic [1:0] r;
      cmd(32'h210);
      axw(`SBT_OFF_RANGE, 32'h3003_3000, r);
      axw(`SBT_OFF_CFG, 32'h4, r);
      cmd(32'h1);
      tr(16'h2fff, 1'b0, 1'b0);
      tr(16'h3000, 1'b0, 1'b1);
      tr(16'h3003, 1'b0, 1'b1);
      tr(16'h3004, 1'b0, 1'b0);
      axw(`SBT_OFF_CFG, 32'h8, r);
      tr(16'h3001, 1'b0, 1'b0);
      tr(16'h3002, 1'b1, 1'b1);
      axw(`SBT_OFF_CFG, 32'h0, r);
      tr(16'h3002, 1'b1, 1'b0);
      axw(`SBT_OFF_CFG, 32'h14, r);
      tr(16'h3001, 1'b0, 1'b1);
      `CHK("halted", 1'b0, trun)
      cmd(32'h1);
      tr(16'h3002, 1'b0, 1'b1);
   endtask
   // Main sequence: reset for 8 cycles, then every scenario in turn.
   initial begin
      {awa, ara, wd, awv, wv, brdy, arv, rrdy} = '0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      s_idle();
      s_mode();
      s_cfg();
      s_bp();
      s_many();
      s_reset();
      s_preload();
      s_patch();
      s_inspect();
      s_trace();
      tally_and_finish();
   end
endmodule // tb_sbt_top
`default_nettype wire
